// ==== hw/icp_pins.sv ====
// Expansion-bus command and upper address pin control.
// Assumes internal bus logic on the core clock supplies ownership, cycle type,
// address and mode; pin wires are resolved outside from the enables.
//
// Behaviour
// - Drive I/O write when owning or in extended mode, else input
// - Strobes float in reset, high after, in suspend
// - Seven upper address lines driven when owning
// - Upper address lines input under external master
// - Extended mode turns address into general outputs
// - Address floats in reset, holds during suspend
// - Wide select ignored for I/O and refresh
// - Sample wide select; drive low for master-to-PCI
// - Wide select floats in reset, after, suspend
// - Drive memory read when master or in extended mode, else input
// - Memory read also driven during refresh
// - Memory read asserted for DMA memory side
`default_nettype none
module icp_pins
    import icp_pkg::*;
#(
    parameter int LA_W = LA_WIDTH
) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    input wire logic i_own_bus,
    input wire logic i_eio_mode,
    input wire logic i_pos,
    input wire icp_cmd_t i_cmd,
    input wire logic [LA_W-1:0] i_addr,
    input wire logic [LA_W-1:0] i_gpo,
    input wire logic i_master_pci_mem,
    input wire logic i_io_write_strobe_n,
    input wire logic i_memory_read_strobe_n,
    input wire logic [LA_W-1:0] i_upper_addr,
    input wire logic i_wide_memory_select_n,
    output logic o_io_write_strobe_n,
    output logic o_io_write_strobe_oe,
    output logic o_memory_read_strobe_n,
    output logic o_memory_read_strobe_oe,
    output logic [LA_W-1:0] o_upper_addr,
    output logic o_upper_addr_oe,
    output logic o_wide_memory_select_n,
    output logic o_wide_memory_select_oe,
    output logic o_ext_io_write_n,
    output logic o_ext_memory_read_n,
    output logic [LA_W-1:0] o_ext_upper_addr,
    output logic o_wide_cycle
);
    localparam int SW = LA_W + 3;

    logic [SW-1:0] pins_sync;
    logic ext_iow_n;
    logic ext_memory_read_strobe_n;
    logic ext_wide_n;
    logic [LA_W-1:0] ext_la;

    icp_sync #(
        .WIDTH(SW),
        .INIT({{LA_W{1'b0}}, 3'b111})
    ) u_sync (
        .i_clk(I_CORE_CLK),
        .i_reset_n(I_RESET_N),
        .i_async({i_upper_addr, i_wide_memory_select_n, i_memory_read_strobe_n,
                  i_io_write_strobe_n}),
        .o_sync(pins_sync)
    );
    assign ext_iow_n = pins_sync[0];
    assign ext_memory_read_strobe_n = pins_sync[1];
    assign ext_wide_n = pins_sync[2];
    assign ext_la = pins_sync[SW-1:3];

    function automatic logic is_mem_cycle(input icp_cmd_t c);
        is_mem_cycle = (c == ICP_CMD_MEM_RD) || (c == ICP_CMD_DMA_RD) || (c == ICP_CMD_MEM_WR);
    endfunction : is_mem_cycle

    icp_drive_t iow_reg, iow_next;
    icp_drive_t memory_read_strobe_reg, memory_read_strobe_next;
    icp_drive_t wide_reg, wide_next;
    icp_la_drive_t la_reg, la_next;
    logic ext_iow_reg, ext_iow_next;
    logic ext_memory_read_strobe_reg, ext_memory_read_strobe_next;
    logic [LA_W-1:0] ext_la_reg, ext_la_next;
    logic wide_cycle_reg, wide_cycle_next;

    always_comb begin
        iow_next = iow_reg;
        memory_read_strobe_next = memory_read_strobe_reg;
        la_next = la_reg;
        wide_next = '{o: 1'b1, oe: 1'b0};
        ext_iow_next = 1'b1;
        ext_memory_read_strobe_next = 1'b1;
        ext_la_next = ext_la_reg;
        wide_cycle_next = 1'b0;
        if (i_pos) begin
            // Suspend: strobes idle high, address pins hold last value
            iow_next = '{o: 1'b1, oe: iow_reg.oe};
            memory_read_strobe_next = '{o: 1'b1, oe: memory_read_strobe_reg.oe};
            la_next = la_reg;
        end else if (i_own_bus || i_eio_mode) begin
            // Extended mode has no external masters, so pins stay outputs
            iow_next = '{o: !(i_cmd == ICP_CMD_IO_WR), oe: 1'b1};
            memory_read_strobe_next.oe = 1'b1;
            memory_read_strobe_next.o = !((i_cmd == ICP_CMD_MEM_RD) ||
                            (i_cmd == ICP_CMD_REFRESH) ||
                            (i_cmd == ICP_CMD_DMA_RD));
            la_next.oe = 1'b1;
            la_next.o = i_eio_mode ? i_gpo : i_addr;
            // Only memory cycles look at wide select
            wide_cycle_next = is_mem_cycle(i_cmd) && !ext_wide_n;
        end else begin
            iow_next = '{o: 1'b1, oe: 1'b0};
            memory_read_strobe_next = '{o: 1'b1, oe: 1'b0};
            la_next.oe = 1'b0;
            ext_iow_next = ext_iow_n;
            ext_memory_read_strobe_next = ext_memory_read_strobe_n;
            ext_la_next = ext_la;
            if (i_master_pci_mem) begin
                wide_next = '{o: 1'b0, oe: 1'b1};
            end
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            // Float every pin in reset; strobes go high right after
            iow_reg <= '{o: 1'b1, oe: 1'b0};
            memory_read_strobe_reg <= '{o: 1'b1, oe: 1'b0};
            la_reg <= '{o: LA_RESET, oe: 1'b0};
            wide_reg <= '{o: 1'b1, oe: 1'b0};
            ext_iow_reg <= 1'b1;
            ext_memory_read_strobe_reg <= 1'b1;
            ext_la_reg <= LA_RESET;
            wide_cycle_reg <= 1'b0;
        end else begin
            iow_reg <= iow_next;
            memory_read_strobe_reg <= memory_read_strobe_next;
            la_reg <= la_next;
            wide_reg <= wide_next;
            ext_iow_reg <= ext_iow_next;
            ext_memory_read_strobe_reg <= ext_memory_read_strobe_next;
            ext_la_reg <= ext_la_next;
            wide_cycle_reg <= wide_cycle_next;
        end
    end

    assign o_io_write_strobe_n = iow_reg.o;
    assign o_io_write_strobe_oe = iow_reg.oe;
    assign o_memory_read_strobe_n = memory_read_strobe_reg.o;
    assign o_memory_read_strobe_oe = memory_read_strobe_reg.oe;
    assign o_upper_addr = la_reg.o;
    assign o_upper_addr_oe = la_reg.oe;
    assign o_wide_memory_select_n = wide_reg.o;
    assign o_wide_memory_select_oe = wide_reg.oe;
    assign o_ext_io_write_n = ext_iow_reg;
    assign o_ext_memory_read_n = ext_memory_read_strobe_reg;
    assign o_ext_upper_addr = ext_la_reg;
    assign o_wide_cycle = wide_cycle_reg;
endmodule : icp_pins
`default_nettype wire

// ==== common/icp_pkg.sv ====
// Shared types and constants for the expansion-bus command/address pin block.
// Assumes a single core clock; all pin inputs are synchronised before use.
`default_nettype none
package icp_pkg;
    localparam int LA_WIDTH = 7;
    localparam int SYNC_STAGES = 2;
    localparam logic [6:0] LA_RESET = 7'h00;

    typedef enum logic [2:0] {
        ICP_CMD_IDLE    = 3'b000,
        ICP_CMD_IO_WR   = 3'b001,
        ICP_CMD_MEM_RD  = 3'b010,
        ICP_CMD_REFRESH = 3'b011,
        ICP_CMD_DMA_RD  = 3'b100,
        ICP_CMD_MEM_WR  = 3'b101
    } icp_cmd_t;

    // One two-way pin: level driven, enable
    typedef struct packed {
        logic o;
        logic oe;
    } icp_drive_t;

    typedef struct packed {
        logic [6:0] o;
        logic oe;
    } icp_la_drive_t;
endpackage : icp_pkg
`default_nettype wire

// ==== hw/icp_sync.sv ====
// Two-flop synchroniser for pin inputs of configurable width.
// Assumes inputs are asynchronous to the core clock.
`default_nettype none
module icp_sync
    import icp_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '1
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] sync_reg;

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_reg <= INIT;
            sync_reg <= INIT;
        end else begin
            meta_reg <= i_async;
            sync_reg <= meta_reg;
        end
    end

    assign o_sync = sync_reg;
endmodule : icp_sync
`default_nettype wire

// ==== bench/icp_pins_properties.sv ====
// Checker bound to the pin block top.
// Assumes one core clock and an async active-low reset.
`default_nettype none
module icp_pins_props import icp_pkg::*; #(parameter int LA_W = LA_WIDTH) (
    input wire logic I_CORE_CLK,
    input wire logic I_RESET_N,
    input wire logic i_own_bus,
    input wire logic i_eio_mode,
    input wire logic i_pos,
    input wire icp_cmd_t i_cmd,
    input wire logic [LA_W-1:0] i_addr,
    input wire logic [LA_W-1:0] i_gpo,
    input wire logic i_master_pci_mem,
    input wire logic o_io_write_strobe_n,
    input wire logic o_io_write_strobe_oe,
    input wire logic o_memory_read_strobe_n,
    input wire logic o_memory_read_strobe_oe,
    input wire logic [LA_W-1:0] o_upper_addr,
    input wire logic o_upper_addr_oe,
    input wire logic o_wide_memory_select_n,
    input wire logic o_wide_memory_select_oe,
    input wire logic o_wide_cycle
);
    default clocking cb @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_RESET_N);
    chk_strobe_dir: assert property (
        !i_pos && !i_eio_mode |=> o_io_write_strobe_oe == $past(i_own_bus)
        && o_memory_read_strobe_oe == o_io_write_strobe_oe) else $error("strobe direction");
    chk_addr_dir: assert property (
        !i_pos && !i_eio_mode |=> o_upper_addr_oe == $past(i_own_bus)
        && (!o_upper_addr_oe || o_upper_addr == $past(i_addr))) else $error("address drive");
    chk_memory_read_strobe_cycles: assert property (
        i_own_bus && !i_pos && i_cmd inside {ICP_CMD_MEM_RD, ICP_CMD_REFRESH, ICP_CMD_DMA_RD}
        |=> !o_memory_read_strobe_n && o_io_write_strobe_n) else $error("read strobe");
    chk_pos_hold: assert property (
        i_pos |=> o_io_write_strobe_n && o_memory_read_strobe_n && $stable(o_upper_addr)
        && $stable(o_upper_addr_oe)) else $error("suspend levels");
    chk_gpo_mode: assert property (
        i_eio_mode && !i_pos |=> o_upper_addr_oe && o_upper_addr == $past(i_gpo))
        else $error("general outputs");
    chk_wide_float: assert property (
        i_pos || i_own_bus |=> !o_wide_memory_select_oe) else $error("wide select driven");
    chk_wide_ignore: assert property (
        i_cmd inside {ICP_CMD_IO_WR, ICP_CMD_REFRESH} |=> !o_wide_cycle) else $error("wide used");
    chk_wide_drive: assert property (
        !i_own_bus && !i_eio_mode && !i_pos && i_master_pci_mem
        |=> o_wide_memory_select_oe && !o_wide_memory_select_n) else $error("wide not low");
    cover property (i_own_bus && i_cmd == ICP_CMD_REFRESH);
    cover property (i_pos && i_own_bus);
    cover property (!i_own_bus && i_master_pci_mem);
endmodule : icp_pins_props
bind icp_pins icp_pins_props #(.LA_W(LA_W)) chk_u (.*);
`default_nettype wire

// ==== bench/icp_far.sv ====
// Far side: one wide memory slave and an outside master.
// Assumes the bench resolves each pin from all enables.
`default_nettype none
module icp_far import icp_pkg::*; (
    input wire logic i_master,
    input wire logic [6:0] i_la,
    output logic o_iow_n,
    output logic o_wide_n
);
    assign o_iow_n = !i_master; // Outside master writes while it owns
    assign o_wide_n = !(i_la == 7'h2a); // Address-only decode, no strobe
    // Data side not modelled
endmodule : icp_far
`default_nettype wire

// ==== bench/isa_command_address_pins_bench.sv ====
// Bench for the pin block: strobes, address, wide select, suspend.
// Assumes the far model stands for slave and outside master.
`default_nettype none
module isa_command_address_pins_bench;
    import icp_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'h0, rst_n = 1'h0, own = 1'h0, extended_io_bus_mode = 1'h0, pos = 1'h0, mpm = 1'h0, fm = 1'h0;
    icp_cmd_t cmd = ICP_CMD_IDLE;
    logic [6:0] addr = 7'h00, gpo = 7'h00, la_o, ext_la;
    logic iow_n, iow_oe, memory_read_strobe_n, memory_read_strobe_oe, la_oe, wide_n, wide_oe, ext_iow_n, f_iow, f_wide;
    logic ext_memory_read_strobe_n, wide_cyc;
    int fails = 0, checked = 0;
    wire logic [6:0] la_pin = la_oe ? la_o : (fm ? 7'h35 : {7{clk}});
    always #5 clk = ~clk;
    icp_pins dut_u (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .i_own_bus(own), .i_eio_mode(extended_io_bus_mode),
        .i_pos(pos), .i_cmd(cmd), .i_addr(addr), .i_gpo(gpo), .i_master_pci_mem(mpm),
        .i_io_write_strobe_n(iow_oe ? iow_n : f_iow), .i_memory_read_strobe_n(memory_read_strobe_oe ? memory_read_strobe_n : 1'h1),
        .i_upper_addr(la_pin), .i_wide_memory_select_n(!(wide_oe && !wide_n) && f_wide),
        .o_io_write_strobe_n(iow_n), .o_io_write_strobe_oe(iow_oe), .o_memory_read_strobe_n(memory_read_strobe_n),
        .o_memory_read_strobe_oe(memory_read_strobe_oe), .o_upper_addr(la_o), .o_upper_addr_oe(la_oe),
        .o_wide_memory_select_n(wide_n), .o_wide_memory_select_oe(wide_oe),
        .o_ext_io_write_n(ext_iow_n), .o_ext_memory_read_n(ext_memory_read_strobe_n), .o_ext_upper_addr(ext_la),
        .o_wide_cycle(wide_cyc));
    icp_far far_u (.i_master(fm), .i_la(la_pin), .o_iow_n(f_iow), .o_wide_n(f_wide));
    task automatic check(input logic [15:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: %h not %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input logic o, e, p, icp_cmd_t c, logic [6:0] a);
        @(posedge clk);
        {own, extended_io_bus_mode, pos, addr, gpo} <= {o, e, p, a, ~a};
        cmd <= c;
        @(posedge clk);
        #1;
    endtask : step
    task automatic report_and_stop;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : report_and_stop
    initial begin
        icp_cmd_t c[6] = '{ICP_CMD_IO_WR, ICP_CMD_MEM_RD, ICP_CMD_REFRESH, ICP_CMD_DMA_RD,
            ICP_CMD_MEM_WR, ICP_CMD_IDLE};
        logic [1:0] e[6] = '{2'h1, 2'h2, 2'h2, 2'h2, 2'h3, 2'h3};
        repeat (3) @(posedge clk);
        check({iow_oe, memory_read_strobe_oe, la_oe, wide_oe}, 4'h0);
        rst_n <= 1'h1;
        for (int k = 0; k < 6; k++) begin
            step(1'h1, 1'h0, 1'h0, c[k], 7'h01 << k);
            check({iow_n, memory_read_strobe_n, iow_oe, memory_read_strobe_oe, la_oe}, {e[k], 3'h7});
            check(la_o, 7'h01 << k);
        end
        $display("own cycles done");
        @(posedge clk);
        {fm, mpm} <= 2'h3;
        step(1'h0, 1'h0, 1'h0, ICP_CMD_IDLE, 7'h00);
        check({iow_oe, memory_read_strobe_oe, la_oe, wide_oe, wide_n}, 5'h02);
        repeat (3) @(posedge clk);
        #1;
        check({ext_iow_n, ext_memory_read_strobe_n, ext_la}, {1'h0, 1'h1, 7'h35});
        {fm, mpm} <= 2'h0;
        $display("outside master done");
        // Far slave decodes 2a; sync adds two edges, result register one more
        step(1'h1, 1'h0, 1'h0, ICP_CMD_MEM_RD, 7'h2a);
        repeat (3) @(posedge clk);
        #1;
        check(wide_cyc, 1'h1);
        step(1'h1, 1'h0, 1'h0, ICP_CMD_IO_WR, 7'h2a);
        check(wide_cyc, 1'h0);
        $display("wide select done");
        step(1'h1, 1'h0, 1'h0, ICP_CMD_MEM_RD, 7'h44);
        step(1'h1, 1'h0, 1'h1, ICP_CMD_MEM_RD, 7'h03);
        check({iow_n, memory_read_strobe_n, wide_oe, la_oe, la_o}, {4'hd, 7'h44});
        step(1'h0, 1'h1, 1'h0, ICP_CMD_IDLE, 7'h0f);
        check({la_oe, la_o}, {1'h1, 7'h70});
        $display("suspend and general outputs done");
        report_and_stop;
    end
    initial begin
        repeat (400) @(posedge clk);
        fails++;
        report_and_stop;
    end
endmodule : isa_command_address_pins_bench
`default_nettype wire
